// ---- obe_cfg.svh ----
// Constants for the one-bit enable-gated execution unit: register offsets,
// field positions and reset values.
// Assumes a 32-bit APB register bus with word-aligned byte addresses.
`ifndef OBE_CFG_SVH
`define OBE_CFG_SVH

// ============================================================
// Register byte offsets
`define OBE_CTRL_OFS        8'h00
`define OBE_STATUS_OFS      8'h04
`define OBE_COUNT_OFS       8'h08

// ============================================================
// Control register fields
`define OBE_CTRL_RUN_BIT    0
`define OBE_CTRL_RESET      1'b1

// ============================================================
// Status register fields
`define OBE_ST_RESULT_BIT   0
`define OBE_ST_ENABLE_BIT   1
`define OBE_ST_INEN_BIT     2
`define OBE_ST_SKIP_BIT     3

// ============================================================
// Reset values of the execution state
`define OBE_RESULT_RESET    1'b0
`define OBE_ENABLE_RESET    1'b0
`define OBE_INEN_RESET      1'b0

`endif

// ---- obe_pkg.sv ----
// Types shared by the one-bit enable-gated execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package obe_pkg;

	// ============================================================
	// Instruction codes, one instruction per clock
	typedef enum logic [3:0] {
		OBE_IDLE_ZERO   = 4'h0,
		OBE_FETCH_INPUT = 4'h1,
		OBE_FETCH_INV   = 4'h2,
		OBE_AND         = 4'h3,
		OBE_AND_INV     = 4'h4,
		OBE_OR          = 4'h5,
		OBE_OR_INV      = 4'h6,
		OBE_XNOR        = 4'h7,
		OBE_WRITE       = 4'h8,
		OBE_WRITE_INV   = 4'h9,
		OBE_INPUT_EN    = 4'ha,
		OBE_OUTPUT_EN   = 4'hb,
		OBE_JUMP        = 4'hc,
		OBE_RETURN      = 4'hd,
		OBE_SKIP_ZERO   = 4'he,
		OBE_IDLE_LAST   = 4'hf
	} obe_op_t;

endpackage : obe_pkg

// ---- obe_logic_unit.sv ----
// Combinational logic unit: next value of the result bit for one instruction.
// Assumes the operand bit has already been gated by the input enable.
`timescale 1ns/1ps

module obe_logic_unit
	import obe_pkg::*;
(
	input  wire obe_op_t op,
	input  wire logic    result_bit,
	input  wire logic    operand,
	output logic         result_next
);

	// ============================================================
	// Result bit update
	always_comb
	begin
		unique case (op)
			OBE_FETCH_INPUT: result_next = operand;
			OBE_FETCH_INV:   result_next = ~operand;
			OBE_AND:         result_next = result_bit & operand;
			OBE_AND_INV:     result_next = result_bit & ~operand;
			OBE_OR:          result_next = result_bit | operand;
			// With the operand wired to the result bit this yields 1.
			OBE_OR_INV:      result_next = result_bit | ~operand;
			OBE_XNOR:        result_next = ~(result_bit ^ operand);
			default:         result_next = result_bit;
		endcase
	end

endmodule : obe_logic_unit

// ---- obe_exec_unit.sv ----
// Execution control of a one-bit control processor with an APB register port.
// Assumes an external program counter, instruction memory and addressed I/O
// latches; the addressed input bit arrives on operand_in in the same cycle.
//
// What this block does
// - Write strobe appears only while the output enable latch holds 1.
// - Output enable latch loads from any addressed input bit, gated by the input enable.
// - Enable load addressed at the result bit copies it into the latch; the output enable only while the input enable holds 1.
// - Fetch instruction copies the addressed input, gated by the input enable, into the result bit.
// - Store writes the result bit, inverted store writes its complement.
// - OR-with-complement on the result bit's own input yields 1.
// - Cycle count per instruction is the same whether enabled or disabled.
// - Every instruction takes exactly one clock period.
// - Idle instruction with code 0 pulses the zero marker flag, whatever its operand.
`timescale 1ns/1ps
`include "obe_cfg.svh"

module obe_exec_unit
	import obe_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  instr_op,
	input  wire logic        operand_in,
	output logic             write_strobe,
	output logic             data_out,
	output logic             result_bit,
	output logic             zero_flag,
	output logic             last_flag,
	output logic             jump_pulse,
	output logic             return_pulse
);

	// ============================================================
	// Declarations
	obe_op_t     op;
	logic        run_q;
	logic        result_bit_register_q;
	logic        output_enable_latch_q;
	logic        input_enable_q;
	logic        skip_q;
	logic [15:0] count_q;
	logic        execute;
	logic        operand;
	logic        result_next;
	logic        write_result_op;
	logic        write_inverted_op;
	logic        idle_op;
	logic        access;
	logic        wr_take;
	logic        addr_ok;
	logic [31:0] rd_mux;

	assign op                = obe_op_t'(instr_op);
	// A skipped instruction still consumes its clock period, so timing stays fixed.
	assign execute           = run_q & ~skip_q;
	assign operand           = operand_in & input_enable_q;
	assign write_result_op   = (op == OBE_WRITE);
	assign write_inverted_op = (op == OBE_WRITE_INV);
	assign idle_op           = (op == OBE_IDLE_ZERO) | (op == OBE_IDLE_LAST);

	obe_logic_unit u_logic
	(
		.op          (op),
		.result_bit  (result_bit_register_q),
		.operand     (operand),
		.result_next (result_next)
	);

	// ============================================================
	// Result bit register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_bit_register_q <= `OBE_RESULT_RESET;
		else if (execute)
			result_bit_register_q <= result_next;
	end

	// ============================================================
	// Output enable and input enable latches
	// The input enable loads the addressed input directly and the output enable loads it gated by the input enable,
	// so with input enabled a tied input gives a constant enable and the fed-back result bit gives a computed one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			output_enable_latch_q <= `OBE_ENABLE_RESET;
		else if (execute && op == OBE_OUTPUT_EN)
			output_enable_latch_q <= operand;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			input_enable_q <= `OBE_INEN_RESET;
		else if (execute && op == OBE_INPUT_EN)
			input_enable_q <= operand_in;
	end

	// ============================================================
	// Skip on zero: the next instruction is ignored but still takes its cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			skip_q <= 1'b0;
		else if (run_q)
			skip_q <= ~skip_q & (op == OBE_SKIP_ZERO) & ~result_bit_register_q;
	end

	// ============================================================
	// Write strobe and data
	// The strobe is registered, so it stands for the one period after the
	// store is sampled; disabled stores advance exactly as enabled ones do.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			write_strobe <= 1'b0;
			data_out     <= 1'b0;
		end
		else
		begin
			write_strobe <= execute & output_enable_latch_q
			                & (write_result_op | write_inverted_op);
			if (execute && write_result_op)
				data_out <= result_bit_register_q;
			else if (execute && write_inverted_op)
				data_out <= ~result_bit_register_q;
		end
	end

	// ============================================================
	// Flag pulses, one clock each
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zero_flag    <= 1'b0;
			last_flag    <= 1'b0;
			jump_pulse   <= 1'b0;
			return_pulse <= 1'b0;
		end
		else
		begin
			zero_flag    <= execute & (op == OBE_IDLE_ZERO);
			last_flag    <= execute & (op == OBE_IDLE_LAST);
			jump_pulse   <= execute & (op == OBE_JUMP);
			return_pulse <= execute & (op == OBE_RETURN);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_bit <= `OBE_RESULT_RESET;
		else
			result_bit <= result_next & execute | result_bit_register_q & ~execute;
	end

	// ============================================================
	// Executed-instruction counter, wraps at 16 bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_q <= 16'h0000;
		else if (execute)
			count_q <= count_q + 16'h0001;
	end

	// ============================================================
	// APB slave: no wait states, every access answered in its second cycle
	assign access  = psel & penable & pready;
	assign wr_take = access & pwrite & addr_ok;
	assign addr_ok = (paddr == `OBE_CTRL_OFS) | (paddr == `OBE_STATUS_OFS)
	                 | (paddr == `OBE_COUNT_OFS);

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`OBE_CTRL_OFS:   rd_mux[`OBE_CTRL_RUN_BIT] = run_q;
			`OBE_STATUS_OFS:
			begin
				rd_mux[`OBE_ST_RESULT_BIT] = result_bit_register_q;
				rd_mux[`OBE_ST_ENABLE_BIT] = output_enable_latch_q;
				rd_mux[`OBE_ST_INEN_BIT]   = input_enable_q;
				rd_mux[`OBE_ST_SKIP_BIT]   = skip_q;
			end
			`OBE_COUNT_OFS:  rd_mux[15:0] = count_q;
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// Clearing the run bit freezes execution; writes to status or count are ignored.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_q <= `OBE_CTRL_RESET;
		else if (wr_take && paddr == `OBE_CTRL_OFS)
			run_q <= pwdata[`OBE_CTRL_RUN_BIT];
	end

endmodule : obe_exec_unit

// ---- obe_exec_unit_assertions.sv ----
// Checker for the execution unit, watching its top-level ports only.
// Assumes instructions arrive only while the run bit is set and skip-if-zero is never issued.
`timescale 1ns/1ps
module obe_chk
	import obe_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic [3:0] instr_op,
	input wire logic       operand_in,
	input wire logic       write_strobe,
	input wire logic       data_out,
	input wire logic       result_bit,
	input wire logic       zero_flag
);
	logic ien_q;
	logic oen_q;
	// ============================================================
	// Shadow enables, since the latches themselves are not visible.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) ien_q <= 1'b0;
		else if (instr_op == 4'ha) ien_q <= operand_in;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) oen_q <= 1'b0;
		else if (instr_op == 4'hb) oen_q <= operand_in & ien_q;
	// ============================================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	strobe_cause_a: assert property (write_strobe |-> $past(instr_op) inside {4'h8, 4'h9})
		else $error("strobe without a store");
	strobe_on_a: assert property (instr_op inside {4'h8, 4'h9} && oen_q |=> write_strobe)
		else $error("enabled store gave no strobe");
	strobe_off_a: assert property (!oen_q |=> !write_strobe)
		else $error("strobe while disabled");
	store_value_a: assert property (write_strobe && $past(instr_op) == 4'h8 |-> data_out == result_bit)
		else $error("store value wrong");
	inv_value_a: assert property (write_strobe && $past(instr_op) == 4'h9 |-> data_out != result_bit)
		else $error("inverted store value wrong");
	fetch_copy_a: assert property (instr_op == 4'h1 && ien_q |=> result_bit == $past(operand_in))
		else $error("fetch did not copy operand");
	orc_one_a: assert property (instr_op == 4'h6 && operand_in == result_bit |=> result_bit)
		else $error("or-complement left result at 0");
	zero_pulse_a: assert property (instr_op == 4'h0 |=> zero_flag ##1 (zero_flag == $past(instr_op == 4'h0)))
		else $error("zero marker pulse wrong");
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	cover property (write_strobe);
	cover property (zero_flag);
	cover property (instr_op == 4'h6 && !result_bit);
endmodule : obe_chk

bind obe_exec_unit obe_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .instr_op(instr_op), .operand_in(operand_in), .write_strobe(write_strobe),
	.data_out(data_out), .result_bit(result_bit), .zero_flag(zero_flag));

// ---- obe_far_model.sv ----
// Far side: program counter, program store and eight addressed bit latches.
// Assumes write_strobe follows the store one clock later.
`timescale 1ns/1ps
module obe_far_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic       write_strobe,
	input  wire logic       data_out,
	input  wire logic       result_bit,
	input  wire logic       zero_flag,
	input  wire logic       last_flag,
	output logic      [3:0] instr_op,
	output logic            operand_in,
	output logic      [7:0] bits_q,
	output logic      [7:0] gang_q
);
	logic       user_strobe;
	logic [6:0] rom [16];
	logic [3:0] pc_q;
	logic [2:0] addr_q;
	logic [7:0] in_vec;
	// ============================================================
	// Address 0 is the result bit, 1 and 2 are tied high and low.
	assign in_vec     = {bits_q[7:3], 1'b0, 1'b1, result_bit};
	assign instr_op   = go ? rom[pc_q][6:3] : 4'hf;
	assign operand_in = in_vec[rom[pc_q][2:0]];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) pc_q <= 4'h0;
		else if (zero_flag) pc_q <= 4'h0;
		else if (go) pc_q <= pc_q + 4'h1;
	always_ff @(posedge pclk)
		addr_q <= rom[pc_q][2:0];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) bits_q <= 8'h08;
		else if (write_strobe) bits_q[addr_q] <= data_out;
	// ============================================================
	// The last-idle pulse gated by operand field 7 of the same instruction
	// makes a user strobe, which captures all bit latches at once.
	assign user_strobe = last_flag & (addr_q == 3'h7);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) gang_q <= 8'h00;
		else if (user_strobe) gang_q <= bits_q;
endmodule : obe_far_model

// ---- test_one_bit_enable_gated_execution.sv ----
// Self-checking bench: APB register access and an enable-gated program.
// Assumes a one-cycle APB access phase and the far-side model.
`timescale 1ns/1ps
module test_one_bit_enable_gated_execution;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        go = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, operand_in, write_strobe, data_out, result_bit, zero_flag;
	logic        last_flag, jump_pulse, return_pulse;
	logic [7:0]  gang;
	logic [3:0]  instr_op;
	logic [7:0]  bits;
	int          err_total = 0;
	int          tests_run = 0;
	int          cyc = 0;
	// Disabled store at slot 3, then store, two idles, inverted store, restart, gang strobe.
	logic [6:0] prog [12] = '{7'h51, 7'h0a, 7'h58, 7'h43, 7'h30, 7'h58, 7'h44, 7'h78, 7'h78, 7'h4c, 7'h00, 7'h7f};
	obe_exec_unit u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_op(instr_op), .operand_in(operand_in), .write_strobe(write_strobe), .data_out(data_out),
		.result_bit(result_bit), .zero_flag(zero_flag), .last_flag(last_flag), .jump_pulse(jump_pulse),
		.return_pulse(return_pulse));
	obe_far_model u_far (.pclk(pclk), .presetn(presetn), .go(go), .write_strobe(write_strobe),
		.data_out(data_out), .result_bit(result_bit), .zero_flag(zero_flag), .last_flag(last_flag),
		.instr_op(instr_op), .operand_in(operand_in), .bits_q(bits), .gang_q(gang));
	always #12.5 pclk = ~pclk;
	// ============================================================
	// Shared tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task report_and_stop;
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// ============================================================
	// Scenarios
	task run_apb;
		logic [31:0] q;
		logic [31:0] c0;
		logic        e;
		apb(1'b0, 8'h00, 32'h0, q, e);
		chk("ctrl_reset", 32'h1, q);
		apb(1'b1, 8'h04, 32'hff, q, e);
		apb(1'b0, 8'h04, 32'h0, q, e);
		chk("status_reset", 32'h0, q);
		apb(1'b0, 8'h0c, 32'h0, q, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		chk("unmapped_rd", 32'h0, q);
		apb(1'b0, 8'h08, 32'h0, q, e);
		c0 = q;
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk("count_step", 32'd3, q - c0);
		apb(1'b1, 8'h00, 32'h0, q, e);
		apb(1'b0, 8'h00, 32'h0, q, e);
		chk("ctrl_clear", 32'h0, q);
		apb(1'b0, 8'h08, 32'h0, q, e);
		c0 = q;
		apb(1'b0, 8'h08, 32'h0, q, e);
		chk("count_frozen", 32'h0, q - c0);
		apb(1'b1, 8'h00, 32'h1, q, e);
	endtask : run_apb
	task run_gated;
		logic [31:0] hi;
		logic [31:0] strobes;
		logic [31:0] zeros;
		logic [31:0] q;
		logic        e;
		hi = 0;
		strobes = 0;
		zeros = 0;
		for (int i = 0; i < 12; i++) u_far.rom[i] = prog[i];
		@(posedge pclk);
		go <= 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			@(negedge pclk);
			hi += bits[4];
			strobes += write_strobe;
			zeros += zero_flag;
		end
		@(posedge pclk);
		go <= 1'b0;
		chk("strobes", 32'd2, strobes);
		chk("latch3", 32'h1, {31'h0, bits[3]});
		chk("high_cycles", 32'd3, hi);
		chk("latch4", 32'h0, {31'h0, bits[4]});
		chk("zero_pulses", 32'd1, zeros);
		apb(1'b0, 8'h04, 32'h0, q, e);
		chk("status_run", 32'h7, q);
		chk("gang", 32'h08, {24'h0, gang});
	endtask : run_gated
	task run_pulses;
		u_far.rom[1] = 7'h60;
		u_far.rom[2] = 7'h68;
		@(posedge pclk);
		go <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		chk("jump_pulse", 32'h1, {31'h0, jump_pulse});
		@(posedge pclk);
		go <= 1'b0;
		@(negedge pclk);
		chk("return_pulse", 32'h1, {31'h0, return_pulse});
		chk("jump_end", 32'h0, {31'h0, jump_pulse});
	endtask : run_pulses
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		run_apb();
		run_gated();
		run_pulses();
		report_and_stop();
	end
endmodule : test_one_bit_enable_gated_execution
